// >>> hw/pc_stack_context_regs.sv
// program counter, return stack and interrupt context copy registers
// ====================================================================
// Contract
// RQ1: program counter is fifteen bits wide
// RQ2: pc low byte readable and writable
// RQ3: pc upper bits only via high latch
// RQ4: every reset clears the program counter (here only rst_n clears it; porRst_n alone does not)
// RQ5: unimplemented bits read zero, writes ignored
// RQ6: software writes zero to reserved locations
// RQ7: low byte write loads upper bits too
// RQ8: push increments then stores; pop reloads then decrements
// RQ9: pointer 0x1F means empty stack
// RQ10: top of stack pair reaches selected entry
// RQ11: interrupt entry copies context; kept over warm reset
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "pc_stack_params.svh"
module pc_stack_context_regs (
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   porRst_n,
   input  wire pc_stack_pkg::addr_type regAddr,
   input  wire pc_stack_pkg::byte_type regWdata,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output      pc_stack_pkg::byte_type regRdata,
   input  wire pc_stack_pkg::stack_op_type stackOp,
   input  wire pc_stack_pkg::pc_type   pcTarget,
   input  wire logic                   pcLoad,
   input  wire logic                   pcStep,
   input  wire logic                   intEntry,
   input  wire pc_stack_pkg::byte_type ctxStatus,
   input  wire pc_stack_pkg::byte_type ctxWork,
   input  wire pc_stack_pkg::byte_type ctxBank,
   input  wire pc_stack_pkg::byte_type ctxP0Low,
   input  wire pc_stack_pkg::byte_type ctxP0High,
   input  wire pc_stack_pkg::byte_type ctxP1Low,
   input  wire pc_stack_pkg::byte_type ctxP1High,
   output      pc_stack_pkg::pc_type   pcValue,
   output      pc_stack_pkg::sp_type   spValue
);
   import pc_stack_pkg::*;

   // ==================================================================
   // state
   pc_type   pc;
   sp_type   sp;
   byte_type pcLatch;
   byte_type ctx [0:7];
   pc_type   stack [0:`PCS_DEPTH-1];
   byte_type rdata;

   // ==================================================================
   // decode
   function automatic logic hit(input addr_type a, input addr_type off);
      hit = (a == off);
   endfunction

   wire logic wrPcLow  = regWrite && hit(regAddr, `PCS_OFF_PC_LOW);
   wire logic wrLatch  = regWrite && hit(regAddr, `PCS_OFF_PC_LATCH);
   wire logic wrSp     = regWrite && hit(regAddr, `PCS_OFF_SP);
   wire logic wrTosLow = regWrite && hit(regAddr, `PCS_OFF_TOS_LOW);
   wire logic wrTosHi  = regWrite && hit(regAddr, `PCS_OFF_TOS_HIGH);
   // sixteen entries: the index wraps, overflow handling lives outside this bank
   wire logic [3:0] spIdx = sp[3:0];
   wire pc_type tos    = stack[spIdx];
   wire sp_type spInc  = sp + 5'h01;
   wire logic [3:0] pushIdx = spInc[3:0];
   wire logic doPush   = (stackOp == CORE_PUSH) || intEntry;
   // an interrupt entry pushes even while the core asks for a pop
   wire logic doPop    = (stackOp == CORE_POP) && !intEntry;

   // per-register write masks drop unimplemented bits
   function automatic byte_type ctxMask(input int i);
      case (i)
         0:       ctxMask = `PCS_STATUS_MASK;
         2:       ctxMask = `PCS_BANK_MASK;
         3:       ctxMask = `PCS_HI7_MASK;
         default: ctxMask = 8'hFF;
      endcase
   endfunction

   wire byte_type ctxSrc [0:7];
   assign ctxSrc[0] = ctxStatus;
   assign ctxSrc[1] = ctxWork;
   assign ctxSrc[2] = ctxBank;
   assign ctxSrc[3] = pcLatch;
   assign ctxSrc[4] = ctxP0Low;
   assign ctxSrc[5] = ctxP0High;
   assign ctxSrc[6] = ctxP1Low;
   assign ctxSrc[7] = ctxP1High;

   // ==================================================================
   // program counter and latch
   wire pc_type next_pc =
      wrPcLow ? {pcLatch[6:0], regWdata} :                   // RQ7 RQ3 RQ2
      doPop   ? tos :                                        // RQ8
      pcLoad  ? pcTarget :
      pcStep  ? pc + 15'h0001 : pc;                          // RQ1

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc      <= `PCS_PC_RESET;                           // RQ4
         pcLatch <= `PCS_BYTE_RESET;
      end else begin
         pc <= next_pc;
         if (wrLatch) begin
            pcLatch <= regWdata & `PCS_HI7_MASK;             // RQ5
         end
      end
   end

   // ==================================================================
   // stack pointer and entries
   wire sp_type next_sp =
      doPush ? spInc :                                       // RQ8
      doPop  ? sp - 5'h01 :                                  // RQ9
      wrSp   ? regWdata[4:0] : sp;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sp <= `PCS_SP_EMPTY;                                // RQ9
      end else begin
         sp <= next_sp;
      end
   end

   // entries are plain storage with no reset, like the rest of the stack ram
   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         stack[pushIdx] <= pc;                               // RQ8
      end else if (wrTosLow) begin
         stack[spIdx][7:0] <= regWdata;                      // RQ10
      end else if (wrTosHi) begin
         stack[spIdx][14:8] <= regWdata[6:0];                // RQ10
      end
   end

   // ==================================================================
   // context copies: of the two resets only the power-on reset touches them
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gCtx
         wire logic wrCtx = regWrite && hit(regAddr, `PCS_OFF_STATUS_CC + 12'(g));
         always_ff @(posedge clk_sys or negedge porRst_n) begin
            if (!porRst_n) begin
               ctx[g] <= `PCS_BYTE_RESET;
            end else if (intEntry) begin
               ctx[g] <= ctxSrc[g] & ctxMask(g);             // RQ11
            end else if (wrCtx) begin
               ctx[g] <= regWdata & ctxMask(g);              // RQ5
            end
         end
      end
   endgenerate

   // ==================================================================
   // read path
   wire logic inCtx = regAddr >= `PCS_OFF_STATUS_CC && regAddr <= `PCS_OFF_P1H_CC;
   wire logic [2:0] ctxIdx = 3'(regAddr - `PCS_OFF_STATUS_CC);
   wire byte_type rdMux =
      inCtx                              ? ctx[ctxIdx] :
      hit(regAddr, `PCS_OFF_PC_LOW)      ? pc[7:0] :         // RQ2
      hit(regAddr, `PCS_OFF_PC_LATCH)    ? pcLatch :
      hit(regAddr, `PCS_OFF_SP)          ? {3'h0, sp} :      // RQ5
      hit(regAddr, `PCS_OFF_TOS_LOW)     ? tos[7:0] :        // RQ10
      hit(regAddr, `PCS_OFF_TOS_HIGH)    ? {1'b0, tos[14:8]} :
      8'h00;                                                 // RQ5

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= `PCS_BYTE_RESET;
      end else begin
         rdata <= regRead ? rdMux : `PCS_BYTE_RESET;
      end
   end

   assign regRdata = rdata;
   assign pcValue  = pc;
   assign spValue  = sp;

   // ==================================================================
   // checks: program counter
   chk_pc_low_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ7
      wrPcLow |=> pc == {$past(pcLatch[6:0]), $past(regWdata)})
      else $error("pc low write did not load full pc");
   chk_pc_reset: assert property (@(posedge clk_sys) // RQ4
      !rst_n |=> pc == `PCS_PC_RESET)
      else $error("pc not cleared in reset");
   chk_pc_upper: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
      !wrPcLow && !doPop && !pcLoad && !pcStep |=> pc == $past(pc))
      else $error("pc changed without cause");
   chk_pc_step: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
      pcStep && !wrPcLow && !doPop && !pcLoad |=> pc == $past(pc) + 15'h0001)
      else $error("pc step did not wrap in fifteen bits");
   chk_pc_load: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
      pcLoad && !wrPcLow && !doPop |=> pc == $past(pcTarget))
      else $error("pc jump load lost");
   chk_latch_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
      wrLatch |=> pcLatch == ($past(regWdata) & `PCS_HI7_MASK))
      else $error("pc high latch write not masked");
   chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
      !wrLatch |=> pcLatch == $past(pcLatch))
      else $error("pc high latch changed without a write");

   // ==================================================================
   // checks: stack pointer and entries
   chk_push_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
      doPush |=> sp == $past(sp) + 5'h01 && stack[sp[3:0]] == $past(pc))
      else $error("push did not increment then store");
   // a low byte write outranks a pop for the pc, so that case is left out here
   chk_pop_order: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
      doPop && !wrPcLow |=> pc == $past(tos) && sp == $past(sp) - 5'h01)
      else $error("pop did not reload then decrement");
   chk_int_over_pop: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
      intEntry && stackOp == CORE_POP && !wrPcLow && !pcLoad && !pcStep
      |=> sp == $past(sp) + 5'h01 && pc == $past(pc))
      else $error("interrupt entry did not override a pop");
   chk_sp_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
      !doPush && !doPop && !wrSp |=> sp == $past(sp))
      else $error("pointer changed without cause");
   chk_pop_empty: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
      doPop && sp == 5'h00 |=> sp == `PCS_SP_EMPTY)
      else $error("last pop did not give empty pointer");
   chk_sp_push_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
      doPush && sp == `PCS_SP_EMPTY |=> sp == 5'h00)
      else $error("first push did not reach entry zero");
   chk_sp_reset: assert property (@(posedge clk_sys) // RQ9
      !rst_n |=> sp == `PCS_SP_EMPTY)
      else $error("pointer not empty after reset");
   chk_sp_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
      wrSp && !doPush && !doPop |=> sp == $past(regWdata[4:0]))
      else $error("pointer write lost");
   chk_tos_low_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
      wrTosLow && !doPush && !doPop |=> tos[7:0] == $past(regWdata))
      else $error("top of stack low write lost");
   chk_tos_high_write: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
      wrTosHi && !doPush && !doPop |=> tos[14:8] == $past(regWdata[6:0]))
      else $error("top of stack high write lost");

   // ==================================================================
   // checks: read path
   chk_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
      regRead && hit(regAddr, `PCS_OFF_SP) |=> regRdata == {3'h0, $past(sp)})
      else $error("pointer read wrong");
   chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
      regRead && hit(regAddr, 12'hFEC) |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   chk_tos_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
      regRead && hit(regAddr, `PCS_OFF_TOS_HIGH) && !doPush && !wrTosHi
      |=> regRdata == {1'b0, $past(tos[14:8])})
      else $error("top of stack high read wrong");
   chk_tos_low_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
      regRead && hit(regAddr, `PCS_OFF_TOS_LOW) |=> regRdata == $past(tos[7:0]))
      else $error("top of stack low read wrong");
   chk_pc_low_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ2
      regRead && hit(regAddr, `PCS_OFF_PC_LOW) |=> regRdata == $past(pc[7:0]))
      else $error("pc low byte read wrong");
   chk_latch_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
      regRead && hit(regAddr, `PCS_OFF_PC_LATCH) |=> regRdata == $past(pcLatch))
      else $error("pc high latch read wrong");
   chk_status_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
      regRead && hit(regAddr, `PCS_OFF_STATUS_CC) |=> regRdata[7:3] == 5'h00)
      else $error("unimplemented status copy bits not zero");
   chk_ctx_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ11
      regRead && inCtx |=> regRdata == $past(ctx[ctxIdx]))
      else $error("context copy read wrong");
   // zero outside the answer cycle keeps a shared read bus clean
   chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
      !regRead |=> regRdata == 8'h00)
      else $error("read data not zero outside answer cycle");

   // ==================================================================
   // checks: context copies, which only the power-on reset clears
   chk_ctx_capture: assert property (@(posedge clk_sys) disable iff (!porRst_n) // RQ11
      intEntry |=> ctx[1] == $past(ctxWork) && ctx[3] == $past(pcLatch))
      else $error("context not captured");
   chk_status_copy_write: assert property (@(posedge clk_sys) disable iff (!porRst_n) // RQ5
      regWrite && hit(regAddr, `PCS_OFF_STATUS_CC) && !intEntry
      |=> ctx[0] == ($past(regWdata) & `PCS_STATUS_MASK))
      else $error("status copy write not masked");
   chk_bank_copy_write: assert property (@(posedge clk_sys) disable iff (!porRst_n) // RQ5
      regWrite && hit(regAddr, `PCS_OFF_BANK_CC) && !intEntry
      |=> ctx[2] == ($past(regWdata) & `PCS_BANK_MASK))
      else $error("bank copy write not masked");
   chk_pcup_copy_write: assert property (@(posedge clk_sys) disable iff (!porRst_n) // RQ5
      regWrite && hit(regAddr, `PCS_OFF_PCUP_CC) && !intEntry
      |=> ctx[3] == ($past(regWdata) & `PCS_HI7_MASK))
      else $error("pc upper copy write not masked");
   // disabled only by the power-on reset, so a warm reset must leave every copy alone
   generate
      for (g = 0; g < 8; g++) begin : gCtxChk
         chk_ctx_hold: assert property (@(posedge clk_sys) disable iff (!porRst_n) // RQ11
            !intEntry && !regWrite |=> ctx[g] == $past(ctx[g]))
            else $error("context copy changed without cause");
         chk_ctx_take: assert property (@(posedge clk_sys) disable iff (!porRst_n) // RQ11
            intEntry |=> ctx[g] == ($past(ctxSrc[g]) & ctxMask(g)))
            else $error("context copy did not capture core value");
      end
   endgenerate

   // ==================================================================
   // main scenarios
   cov_push_pop:   cover property (@(posedge clk_sys) disable iff (!rst_n) doPush ##[1:16] doPop);
   cov_pc_write:   cover property (@(posedge clk_sys) disable iff (!rst_n) wrLatch ##[1:8] wrPcLow);
   cov_int_ctx:    cover property (@(posedge clk_sys) disable iff (!rst_n) intEntry);
   cov_tos_rw:     cover property (@(posedge clk_sys) disable iff (!rst_n) wrTosLow ##2 regRead);
   cov_warm_reset: cover property (@(posedge clk_sys) disable iff (!porRst_n) !rst_n ##1 rst_n);
endmodule

// >>> pkg/pc_stack_params.svh
// offsets, widths, reset values and write masks of the pc, stack and context registers
`ifndef PC_STACK_PARAMS_SVH
`define PC_STACK_PARAMS_SVH
`define PCS_ADDR_W        12
`define PCS_PC_W          15
`define PCS_SP_W          5
`define PCS_DEPTH         16
`define PCS_OFF_STATUS_CC 12'hFE4
`define PCS_OFF_WORK_CC   12'hFE5
`define PCS_OFF_BANK_CC   12'hFE6
`define PCS_OFF_PCUP_CC   12'hFE7
`define PCS_OFF_P0L_CC    12'hFE8
`define PCS_OFF_P0H_CC    12'hFE9
`define PCS_OFF_P1L_CC    12'hFEA
`define PCS_OFF_P1H_CC    12'hFEB
`define PCS_OFF_SP        12'hFED
`define PCS_OFF_TOS_LOW   12'hFEE
`define PCS_OFF_TOS_HIGH  12'hFEF
`define PCS_OFF_PC_LOW    12'h002
`define PCS_OFF_PC_LATCH  12'h00A
`define PCS_SP_EMPTY      5'h1F
`define PCS_PC_RESET      15'h0000
`define PCS_STATUS_MASK   8'h07
`define PCS_BANK_MASK     8'h1F
`define PCS_HI7_MASK      8'h7F
`define PCS_BYTE_RESET    8'h00
`endif

// >>> pkg/pc_stack_pkg.sv
// types of the pc, stack and context register bank
package pc_stack_pkg;
   typedef logic [14:0] pc_type;
   typedef logic [4:0]  sp_type;
   typedef logic [7:0]  byte_type;
   typedef logic [11:0] addr_type;
   typedef enum logic [1:0] {
      CORE_IDLE = 2'b00,
      CORE_PUSH = 2'b01,
      CORE_POP  = 2'b10
   } stack_op_type;
endpackage

// >>> sim/pc_stack_context_regs_tb.sv
// self-checking bench for the pc, stack and context register bank
`timescale 1ns/1ps
`include "pc_stack_params.svh"
module pc_stack_context_regs_tb;
   import pc_stack_pkg::*;
   // ====================================================================
   // stimulus and observed signals
   logic         clk_sys  = 1'b0;
   logic         rst_n    = 1'b0;
   logic         porRst_n = 1'b0;
   addr_type     regAddr  = 12'h000;
   byte_type     regWdata = 8'h00;
   logic         regWrite = 1'b0;
   logic         regRead  = 1'b0;
   byte_type     regRdata;
   stack_op_type stackOp  = CORE_IDLE;
   pc_type       pcTarget = 15'h0000;
   logic         pcLoad   = 1'b0;
   logic         pcStep   = 1'b0;
   logic         intEntry = 1'b0;
   byte_type     ctx [7]  = '{8'hFF, 8'hA5, 8'hFF, 8'h11, 8'h22, 8'h33, 8'h44};
   byte_type     cpy [8]  = '{8'h07, 8'hA5, 8'h1F, 8'h7F, 8'h11, 8'h22, 8'h33, 8'h44};
   pc_type       pcValue;
   sp_type       spValue;
   int           error_cnt = 0;
   int           checks    = 0;
   always #5 clk_sys = ~clk_sys;
   pc_stack_context_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .porRst_n(porRst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stackOp(stackOp),
      .pcTarget(pcTarget), .pcLoad(pcLoad), .pcStep(pcStep), .intEntry(intEntry), .ctxStatus(ctx[0]),
      .ctxWork(ctx[1]), .ctxBank(ctx[2]), .ctxP0Low(ctx[3]), .ctxP0High(ctx[4]), .ctxP1Low(ctx[5]),
      .ctxP1High(ctx[6]), .pcValue(pcValue), .spValue(spValue));
   // ====================================================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input addr_type a, input byte_type d);
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(input addr_type a, input byte_type exp);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 check({8'h00, regRdata}, {8'h00, exp});
   endtask
   // one core cycle: stack op, jump, step, interrupt entry
   task automatic core(input stack_op_type op, input logic ld, input pc_type t, input logic st, input logic ie);
      @(posedge clk_sys);
      stackOp  <= op;
      pcLoad   <= ld;
      pcTarget <= t;
      pcStep   <= st;
      intEntry <= ie;
      @(posedge clk_sys);
      stackOp  <= CORE_IDLE;
      pcLoad   <= 1'b0;
      pcStep   <= 1'b0;
      intEntry <= 1'b0;
      #1;
   endtask
   task automatic resets(input logic por);
      @(posedge clk_sys);
      rst_n    <= 1'b0;
      porRst_n <= ~por;
      repeat (3) @(posedge clk_sys);
      rst_n    <= 1'b1;
      porRst_n <= 1'b1;
      #1;
   endtask
   // ====================================================================
   // scenarios
   task automatic t_reset();
      check({1'b0, pcValue}, 16'h0000);
      check({11'h000, spValue}, {11'h000, `PCS_SP_EMPTY});
      wr(12'hFEC, 8'h00);
      rd(12'hFEC, 8'h00);
      rd(`PCS_OFF_PC_LOW, 8'h00);
   endtask
   task automatic t_pc();
      wr(`PCS_OFF_PC_LATCH, 8'hFF);
      rd(`PCS_OFF_PC_LATCH, `PCS_HI7_MASK);
      check({1'b0, pcValue}, 16'h0000);
      wr(`PCS_OFF_PC_LOW, 8'h34);
      check({1'b0, pcValue}, 16'h7F34);
      rd(`PCS_OFF_PC_LOW, 8'h34);
      core(CORE_IDLE, 1'b1, 15'h7FFF, 1'b0, 1'b0);
      core(CORE_IDLE, 1'b0, 15'h0000, 1'b1, 1'b0);
      check({1'b0, pcValue}, 16'h0000);
   endtask
   task automatic t_stack();
      core(CORE_IDLE, 1'b1, 15'h1234, 1'b0, 1'b0);
      core(CORE_PUSH, 1'b0, 15'h0000, 1'b0, 1'b0);
      rd(`PCS_OFF_SP, 8'h00);
      rd(`PCS_OFF_TOS_LOW, 8'h34);
      rd(`PCS_OFF_TOS_HIGH, 8'h12);
      wr(`PCS_OFF_TOS_LOW, 8'h55);
      wr(`PCS_OFF_TOS_HIGH, 8'hFF);
      rd(`PCS_OFF_TOS_HIGH, 8'h7F);
      core(CORE_POP, 1'b0, 15'h0000, 1'b0, 1'b0);
      check({1'b0, pcValue}, 16'h7F55);
      check({11'h000, spValue}, {11'h000, `PCS_SP_EMPTY});
   endtask
   task automatic t_regs();
      wr(`PCS_OFF_SP, 8'hE3);
      rd(`PCS_OFF_SP, 8'h03);
      wr(`PCS_OFF_TOS_LOW, 8'h9C);
      rd(`PCS_OFF_TOS_LOW, 8'h9C);
      wr(`PCS_OFF_STATUS_CC, 8'hFF);
      rd(`PCS_OFF_STATUS_CC, `PCS_STATUS_MASK);
      wr(`PCS_OFF_BANK_CC, 8'hFF);
      rd(`PCS_OFF_BANK_CC, `PCS_BANK_MASK);
      wr(`PCS_OFF_PCUP_CC, 8'hFF);
      rd(`PCS_OFF_PCUP_CC, `PCS_HI7_MASK);
      wr(`PCS_OFF_SP, 8'h1F);
      check({11'h000, spValue}, {11'h000, `PCS_SP_EMPTY});
   endtask
   task automatic t_ctx();
      core(CORE_IDLE, 1'b1, 15'h0ABC, 1'b0, 1'b0);
      core(CORE_POP, 1'b0, 15'h0000, 1'b0, 1'b1);
      check({11'h000, spValue}, 16'h0000);
      rd(`PCS_OFF_TOS_HIGH, 8'h0A);
      // a warm reset must leave the copies alone, a power-on reset clears them
      resets(1'b0);
      check({1'b0, pcValue}, 16'h0000);
      check({11'h000, spValue}, {11'h000, `PCS_SP_EMPTY});
      for (int i = 0; i < 8; i++) begin
         rd(`PCS_OFF_STATUS_CC + 12'(i), cpy[i]);
      end
      resets(1'b1);
      rd(`PCS_OFF_WORK_CC, 8'h00);
   endtask
   // ====================================================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n    <= 1'b1;
      porRst_n <= 1'b1;
      #1;
      t_reset();
      t_pc();
      t_stack();
      t_regs();
      t_ctx();
      close_out();
   end
   initial begin
      #50us;
      error_cnt++;
      close_out();
   end
endmodule
